/* File: rtl/dil_gate_timer.sv */
// down counter that paces the latch gate phases
`timescale 1ns/100ps
module dil_gate_timer #(
	parameter int unsigned W = 8
) (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] count_i,
	output logic              done_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         done;
	} dil_tmr_t;
	dil_tmr_t s_q, s_d;

	// load then count down, done when reaching zero
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (load_i) begin
			s_d.cnt = count_i;
		end else if (s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - 1'b1;
			s_d.done = (s_q.cnt == {{(W-1){1'b0}}, 1'b1});
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign done_o = s_q.done;
endmodule : dil_gate_timer

/* File: rtl/dil_host.sv */
// host controller writing codes into the converter input latch
`timescale 1ns/100ps
// Summary of operation
// - gate low 60ns, data valid 40ns before
// - data may change as gate rises
// - wide bus: gate from select and strobe
// - narrow bus: separate intermediate byte register
// - narrow: low byte first, then high nibble
// - high nibble and held byte latch together
module dil_host #(
	parameter dil_pkg::dil_bus_t BUS_MODE = dil_pkg::DIL_BUS_WIDE
) (
	input  wire logic             clk_i,
	input  wire logic             resetn_i,
	input  wire dil_pkg::dil_req_t req_i,
	output logic                  ready_o,
	output logic                  gate_n_o,
	output logic [1:12]           data_o,
	output logic [7:0]            low_byte_o,
	output logic                  low_sel_o,
	output logic                  conv_sel_o,
	output logic                  write_n_o,
	output logic                  done_o
);
	typedef struct packed {
		dil_pkg::dil_state_t st;
		dil_pkg::dil_pins_t  pins;
		logic [7:0]          low_q;
		logic                low_sel;
		logic                conv_sel;
		logic                ready;
		logic                done;
		logic                load;
		logic                narrow_phase;
		logic [11:0]         code;
	} dil_state_s_t;
	dil_state_s_t s_q, s_d;
	logic tmr_done;

	// value to pin code: 0 means top of range, full means bottom
	function automatic logic [11:0] to_code(input logic [11:0] v,
	                                         input logic bip);
		logic [11:0] c;
		c = bip ? (v ^ dil_pkg::OFFSET_FLIP) : v;
		return ~c;
	endfunction : to_code

	dil_gate_timer #(.W(dil_pkg::CNT_W)) u_tmr (
		.clk_i   (clk_i),
		.resetn_i(resetn_i),
		.load_i  (s_q.load),
		.count_i (s_q.st == dil_pkg::DIL_IDLE ?
		          dil_pkg::CNT_W'(dil_pkg::SETUP_CYC) :
		          dil_pkg::CNT_W'(dil_pkg::GATE_LOW_CYC)),
		.done_o  (tmr_done)
	);

	// sequencer: write low byte (narrow), then pulse gate with data
	always_comb begin
		s_d = s_q;
		s_d.load = 1'b0;
		s_d.done = 1'b0;
		case (s_q.st)
			dil_pkg::DIL_IDLE: begin
				if (req_i.valid && s_q.ready) begin
					s_d.ready = 1'b0;
					s_d.code = to_code(req_i.value, req_i.bipolar);
					if (BUS_MODE == dil_pkg::DIL_BUS_NARROW) begin
						// first write goes to the byte register
						s_d.low_q = s_d.code[7:0];
						s_d.low_sel = 1'b1;
						s_d.narrow_phase = 1'b1;
						s_d.load = 1'b1;
					end else begin
						s_d.pins.data = s_d.code;
						s_d.conv_sel = 1'b1;
						s_d.pins.gate_n = 1'b0;
						s_d.st = dil_pkg::DIL_LOW;
						s_d.load = 1'b1;
					end
				end else if (s_q.narrow_phase && tmr_done) begin
					// second write: nibble plus held byte in one gate
					s_d.narrow_phase = 1'b0;
					s_d.low_sel = 1'b0;
					s_d.conv_sel = 1'b1;
					s_d.pins.data = {s_q.code[11:8], s_q.low_q};
					s_d.pins.gate_n = 1'b0;
					s_d.st = dil_pkg::DIL_LOW;
					s_d.load = 1'b1;
				end
			end
			dil_pkg::DIL_LOW: begin
				// data set at gate fall; gate low covers 60ns and 40ns
				if (tmr_done) begin
					s_d.pins.gate_n = 1'b1;
					s_d.conv_sel = 1'b0;
					s_d.st = dil_pkg::DIL_HOLD;
				end
			end
			dil_pkg::DIL_HOLD: begin
				// data left steady one more cycle after gate rises
				s_d.done = 1'b1;
				s_d.ready = 1'b1;
				s_d.st = dil_pkg::DIL_IDLE;
			end
			default: begin
				s_d.st = dil_pkg::DIL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_q <= '{st: dil_pkg::DIL_IDLE,
			         pins: '{gate_n: 1'b1, data: dil_pkg::PIN_RESET},
			         low_q: dil_pkg::LOW_RESET, low_sel: 1'b0,
			         conv_sel: 1'b0, ready: 1'b1, done: 1'b0,
			         load: 1'b0, narrow_phase: 1'b0,
			         code: dil_pkg::PIN_RESET};
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from state flops
	assign ready_o    = s_q.ready;
	assign gate_n_o   = s_q.pins.gate_n;
	assign data_o     = s_q.pins.data;
	assign low_byte_o = s_q.low_q;
	assign low_sel_o  = s_q.low_sel;
	assign conv_sel_o = s_q.conv_sel;
	assign write_n_o  = s_q.pins.gate_n;
	assign done_o     = s_q.done;
endmodule : dil_host

/* File: rtl/dil_pkg.sv */
// package for the converter input latch host controller
package dil_pkg;
	localparam int unsigned CLK_HZ          = 50_000_000;
	localparam int unsigned CLK_PERIOD_PS   = 1_000_000_000 / (CLK_HZ / 1000);
	// pin timing of the converter latch gate, in picoseconds
	localparam int unsigned MIN_GATE_LOW_WIDTH_PS = 60_000;
	localparam int unsigned DATA_TO_GATE_SETUP_PS = 40_000;
	localparam int unsigned DATA_AFTER_GATE_HOLD_PS = 0;
	// least times round up, never below one cycle
	function automatic int unsigned cyc_up(input int unsigned ps);
		int unsigned c;
		c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_up
	localparam int unsigned GATE_LOW_CYC = cyc_up(MIN_GATE_LOW_WIDTH_PS);
	localparam int unsigned SETUP_CYC    = cyc_up(DATA_TO_GATE_SETUP_PS);
	localparam int unsigned CNT_W        = 8;
	localparam int unsigned CODE_W       = 12;
	localparam int unsigned LOW_W        = 8;
	localparam int unsigned HIGH_W       = 4;
	// code points
	localparam logic [11:0] CODE_POS_MAX   = 12'h000;
	localparam logic [11:0] CODE_ZERO_BIP  = 12'h7FF;
	localparam logic [11:0] CODE_ALL_ONES  = 12'hFFF;
	localparam logic [11:0] OFFSET_FLIP    = 12'h800;
	localparam logic [7:0]  LOW_RESET      = 8'h00;
	localparam logic [11:0] PIN_RESET      = 12'hFFF;
	// bus width modes of the host
	typedef enum logic {DIL_BUS_WIDE, DIL_BUS_NARROW} dil_bus_t;
	typedef enum logic [1:0] {DIL_IDLE, DIL_LOW, DIL_HOLD} dil_state_t;
	// request from user logic
	typedef struct packed {
		logic        valid;
		logic        bipolar;
		logic [11:0] value;
	} dil_req_t;
	// pins toward the converter
	typedef struct packed {
		logic        gate_n;
		logic [11:0] data;
	} dil_pins_t;
endpackage : dil_pkg

/* File: verif/dil_conv_model.sv */
// converter input latch with its external byte register
`timescale 1ns/100ps
module dil_conv_model (
	input  wire logic        gate_n_i,
	input  wire logic [1:12] data_i,
	input  wire logic [7:0]  byte_i,
	input  wire logic        byte_sel_i,
	output logic [11:0]      code_o
);
	logic [7:0] byte_q;
	// byte register takes the low byte as its select falls
	always_ff @(negedge byte_sel_i) byte_q <= byte_i;
	// transparent while gate low, holds while high; bit 1 is msb
	always_latch begin
		// zero hold: data moving as the gate rises is not taken
		if (!gate_n_i) code_o = {data_i[1:4], byte_q};
	end
endmodule : dil_conv_model

/* File: verif/dil_host_bench.sv */
// bench for the converter latch host controller
`timescale 1ns/100ps
module dil_host_bench;
	logic              clk_i = 0;
	logic              resetn_i = 0;
	dil_pkg::dil_req_t req_i = '0;
	logic              ready_o, gate_n_o, low_sel_o, conv_sel_o, write_n_o;
	logic              done_o;
	logic [1:12]       data_o;
	logic [7:0]        low_byte_o;
	logic [11:0]       code;
	logic              w_ready, w_gate_n, w_low_sel, w_conv_sel, w_write_n;
	logic              w_done;
	logic [1:12]       w_data;
	logic [7:0]        w_low_byte;
	logic [11:0]       corner [4] = '{12'h000, 12'h7FF, 12'h800, 12'hFFF};
	int                err_count = 0;
	int                tests_run = 0;
	always #10 clk_i = ~clk_i;
	dil_host #(.BUS_MODE(dil_pkg::DIL_BUS_NARROW)) i_dil_host (.*);
	// wide bus controller fed the same requests; it finishes earlier
	dil_host #(.BUS_MODE(dil_pkg::DIL_BUS_WIDE)) i_dil_host_wide (
		.clk_i     (clk_i),
		.resetn_i  (resetn_i),
		.req_i     (req_i),
		.ready_o   (w_ready),
		.gate_n_o  (w_gate_n),
		.data_o    (w_data),
		.low_byte_o(w_low_byte),
		.low_sel_o (w_low_sel),
		.conv_sel_o(w_conv_sel),
		.write_n_o (w_write_n),
		.done_o    (w_done)
	);
	dil_conv_model i_dil_conv_model (.gate_n_i(gate_n_o), .data_i(data_o),
		.byte_i(low_byte_o), .byte_sel_i(low_sel_o), .code_o(code));
	function automatic logic [11:0] pin_code(logic [11:0] v, logic b);
		return ~(v ^ {b, 11'h000});
	endfunction : pin_code
	task automatic check(logic [11:0] seen, logic [11:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// one narrow load, then the held code is compared
	task automatic load(logic [11:0] v, logic b);
		int n;
		n = 0;
		while (ready_o !== 1'b1) @(negedge clk_i);
		@(posedge clk_i);
		req_i <= '{1'b1, b, v};
		@(posedge clk_i);
		req_i.valid <= 1'b0;
		while (done_o !== 1'b1 && n < 40) begin
			@(negedge clk_i);
			n++;
		end
		check({11'h000, done_o}, 12'h001);
		check(code, pin_code(v, b));
		check(w_data, pin_code(v, b));
		check({11'h000, w_gate_n}, 12'h001);
	endtask : load
	task automatic conclude();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	// corners in both codings, then random codes
	initial begin
		void'($urandom(93));
		repeat (20) @(posedge clk_i);
		resetn_i <= 1'b1;
		foreach (corner[i]) begin
			load(corner[i], 1'b0);
			load(corner[i], 1'b1);
		end
		repeat (30) load(12'($urandom), 1'($urandom));
		conclude();
	end
	// watchdog against a hung load
	initial begin
		#50us;
		err_count++;
		conclude();
	end
endmodule : dil_host_bench

/* File: verif/dil_host_sva.sv */
// assertions on the converter latch host ports
`timescale 1ns/100ps
module dil_host_sva (
	input wire logic              clk_i,
	input wire logic              resetn_i,
	input wire dil_pkg::dil_req_t req_i,
	input wire logic              ready_o,
	input wire logic              gate_n_o,
	input wire logic [1:12]       data_o,
	input wire logic [7:0]        low_byte_o,
	input wire logic              low_sel_o,
	input wire logic              conv_sel_o,
	input wire logic              write_n_o,
	input wire logic              done_o
);
	logic [11:0] exp_q;
	logic [7:0]  byte_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// pin code of the taken request and copy of the byte register
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			exp_q  <= 12'hFFF;
			byte_q <= 8'h00;
		end else begin
			if (req_i.valid && ready_o) begin
				exp_q <= ~(req_i.value ^ {req_i.bipolar, 11'h000});
			end
			if (low_sel_o) begin
				byte_q <= low_byte_o;
			end
		end
	end
	property p_strobe; write_n_o == gate_n_o && conv_sel_o == !gate_n_o; endproperty
	a_strobe: assert property (p_strobe) else $error("strobe mismatch");
	property p_width; $fell(gate_n_o) |-> !gate_n_o [*3]; endproperty
	a_width: assert property (p_width) else $error("gate too short");
	property p_setup; !gate_n_o && !$past(gate_n_o) |-> $stable(data_o); endproperty
	a_setup: assert property (p_setup) else $error("data moved");
	property p_code; $fell(gate_n_o) |-> data_o == exp_q; endproperty
	a_code: assert property (p_code) else $error("bad pin code");
	// only a gate that follows a byte register write pairs with that byte
	property p_pair;
		$fell(gate_n_o) && $past(low_sel_o) |-> data_o[5:12] == byte_q;
	endproperty
	a_pair: assert property (p_pair) else $error("byte not paired");
	property p_excl; !(low_sel_o && !gate_n_o); endproperty
	a_excl: assert property (p_excl) else $error("both selected");
	property p_done; $rose(gate_n_o) |=> done_o && ready_o; endproperty
	a_done: assert property (p_done) else $error("no done");
	property p_busy; req_i.valid && ready_o |=> !ready_o ##[1:12] done_o; endproperty
	a_busy: assert property (p_busy) else $error("load hung");
endmodule : dil_host_sva
bind dil_host dil_host_sva i_dil_host_sva (.*);
